/* File: fsr_dev.sv */
/*
 * Flash end of the suspend/resume controller: decodes suspend and resume
 * instructions, pauses and resumes the array engine, reports status, and serves
 * the suspend parameter word from the discoverable parameter space.
 * Assumes an array engine on the user side that starts operations, reports
 * their end, and acknowledges a pause request; all on sys_clk_i.
 */
`timescale 1ns/1ps
`include "fsr_defines.svh"

// What this block and fsr_host do
// - suspend supported bit reads zero
// - latency units encoded as 8 us
// - erase suspended within 40 us
// - host waits 128 us resume to suspend
// - program suspended within 40 us
// - host waits 128 us program resume gap
// - no new erase while erase suspended
// - no read in suspended erase sector
// - no erase or program while program suspended
// - no read in suspended program page
// - parameter bytes EC 83 18 44 at 2Ch
// - erase suspend 75h, resume 7Ah
// - program suspend 85h, resume 8Ah
module fsr_dev (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    fsr_link_if.dev link,
    input wire logic op_start_i,
    input wire logic op_is_erase_i,
    input wire logic op_done_i,
    input wire logic array_paused_i,
    output logic array_pause_o,
    output logic late_o,
    output logic fwd_valid_o,
    output logic [7:0] fwd_code_o,
    output logic [23:0] fwd_addr_o,
    output logic busy_o,
    output logic ers_susp_o,
    output logic prg_susp_o
);

    fsr_pkg::fsr_dev_t r_reg;
    fsr_pkg::fsr_dev_t r_next;

    // the whole suspend parameter word, built from its fields
    function automatic logic [31:0] fsr_prm_word();
        fsr_prm_word = {
            `FSR_F_SUP,
            `FSR_F_ERS_LAT_UNIT,
            `FSR_F_ERS_LAT_CNT,
            `FSR_F_ERS_GAP_CNT,
            `FSR_F_PRG_LAT_UNIT,
            `FSR_F_PRG_LAT_CNT,
            `FSR_F_PRG_GAP_CNT,
            `FSR_F_RFU,
            `FSR_F_ERS_PROHIB,
            `FSR_F_PRG_PROHIB
        };
    endfunction : fsr_prm_word

    // byte at one parameter offset, least significant byte at the lowest offset
    function automatic logic [7:0] fsr_prm_byte(input logic [7:0] addr);
        logic [7:0] idx;
        logic [31:0] word;
        idx = 8'(addr - `FSR_PRM_BASE);
        word = fsr_prm_word();
        if (addr >= `FSR_PRM_BASE && addr <= `FSR_PRM_LAST) begin
            fsr_prm_byte = 8'(word >> (idx * `FSR_PRM_BYTE_W));
        end else begin
            // other parameter words are outside this block
            fsr_prm_byte = `FSR_PRM_FILL;
        end
    endfunction : fsr_prm_byte

    // suspend and resume codes stay away from the engine even when ignored
    logic is_susp_cmd;
    logic is_res_cmd;

    always_comb begin
        is_susp_cmd = link.cmd_code == `FSR_CMD_ERS_SUSP || link.cmd_code == `FSR_CMD_PRG_SUSP;
        is_res_cmd = link.cmd_code == `FSR_CMD_ERS_RES || link.cmd_code == `FSR_CMD_PRG_RES;
    end

    always_comb begin
        r_next = r_reg;
        r_next.fwd_valid = 1'b0;
        r_next.prm_valid = 1'b0;

        // parameter reads answer one cycle after the request
        if (link.prm_req) begin
            r_next.prm_valid = 1'b1;
            r_next.prm_data = fsr_prm_byte(link.prm_addr);
        end

        // everything that is not a suspend or resume goes to the array engine
        if (link.cmd_valid && !is_susp_cmd && !is_res_cmd) begin
            r_next.fwd_valid = 1'b1;
            r_next.fwd_code = link.cmd_code;
            r_next.fwd_addr = link.cmd_addr;
        end

        case (r_reg.state)
            fsr_pkg::FSR_IDLE: begin
                // a start while busy or suspended is dropped: the engine cannot nest
                if (op_start_i) begin
                    r_next.state = fsr_pkg::FSR_BUSY;
                    r_next.is_erase = op_is_erase_i;
                end
            end
            fsr_pkg::FSR_BUSY: begin
                // a suspend of the other kind is ignored and the operation runs on
                if (op_done_i) begin
                    r_next.state = fsr_pkg::FSR_IDLE;
                end else if (link.cmd_valid && r_reg.is_erase
                        && link.cmd_code == `FSR_CMD_ERS_SUSP) begin
                    r_next.state = fsr_pkg::FSR_SUSPENDING;
                    r_next.pause = 1'b1;
                    r_next.lat_cnt = '0;
                end else if (link.cmd_valid && !r_reg.is_erase
                        && link.cmd_code == `FSR_CMD_PRG_SUSP) begin
                    r_next.state = fsr_pkg::FSR_SUSPENDING;
                    r_next.pause = 1'b1;
                    r_next.lat_cnt = '0;
                end
            end
            fsr_pkg::FSR_SUSPENDING: begin
                // a resume sent here is ignored; the host must see the suspended status
                r_next.lat_cnt = `FSR_LAT_W'(r_reg.lat_cnt + 1'b1);
                if (op_done_i) begin
                    // finished before it could stop: nothing is left to suspend
                    r_next.state = fsr_pkg::FSR_IDLE;
                    r_next.pause = 1'b0;
                end else if (array_paused_i) begin
                    r_next.state = fsr_pkg::FSR_SUSPENDED;
                end else if (r_reg.lat_cnt == `FSR_LAT_W'(`FSR_SUSP_LAT_LAST)) begin
                    // the reported bound is kept even when the engine is slow;
                    // late_o tells the engine side that it overran
                    r_next.state = fsr_pkg::FSR_SUSPENDED;
                    r_next.late = 1'b1;
                end
            end
            fsr_pkg::FSR_SUSPENDED: begin
                // the engine keeps its place while paused, so dropping the pause resumes it;
                // op_done_i cannot come while paused and is not watched here
                if (link.cmd_valid && r_reg.is_erase
                        && link.cmd_code == `FSR_CMD_ERS_RES) begin
                    r_next.state = fsr_pkg::FSR_BUSY;
                    r_next.pause = 1'b0;
                end else if (link.cmd_valid && !r_reg.is_erase
                        && link.cmd_code == `FSR_CMD_PRG_RES) begin
                    r_next.state = fsr_pkg::FSR_BUSY;
                    r_next.pause = 1'b0;
                end
            end
            default: begin
                r_next.state = fsr_pkg::FSR_IDLE;
                r_next.pause = 1'b0;
            end
        endcase

        // status follows the state it is entering, so it shows with the state
        r_next.busy = r_next.state == fsr_pkg::FSR_BUSY
            || r_next.state == fsr_pkg::FSR_SUSPENDING;
        r_next.ers_susp = r_next.state == fsr_pkg::FSR_SUSPENDED && r_next.is_erase;
        r_next.prg_susp = r_next.state == fsr_pkg::FSR_SUSPENDED && !r_next.is_erase;
    end

    // reset leaves the engine free to run: no pause is asked
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r_reg.state <= fsr_pkg::FSR_IDLE;
            r_reg.is_erase <= 1'b0;
            r_reg.lat_cnt <= '0;
            r_reg.pause <= 1'b0;
            r_reg.late <= 1'b0;
            r_reg.fwd_valid <= 1'b0;
            r_reg.fwd_code <= 8'h00;
            r_reg.fwd_addr <= 24'h000000;
            r_reg.prm_valid <= 1'b0;
            r_reg.prm_data <= 8'h00;
            r_reg.busy <= 1'b0;
            r_reg.ers_susp <= 1'b0;
            r_reg.prg_susp <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.prm_valid = r_reg.prm_valid;
    assign link.prm_data = r_reg.prm_data;
    assign link.busy = r_reg.busy;
    assign link.ers_susp = r_reg.ers_susp;
    assign link.prg_susp = r_reg.prg_susp;

    // the engine sees the pause one edge after the suspend is taken
    assign array_pause_o = r_reg.pause;
    assign late_o = r_reg.late;
    assign fwd_valid_o = r_reg.fwd_valid;
    assign fwd_code_o = r_reg.fwd_code;
    assign fwd_addr_o = r_reg.fwd_addr;
    assign busy_o = r_reg.busy;
    assign ers_susp_o = r_reg.ers_susp;
    assign prg_susp_o = r_reg.prg_susp;

endmodule : fsr_dev

/* File: fsr_defines.svh */
/*
 * Constants for the flash suspend/resume controller: instruction codes, the layout
 * and values of the suspend parameter word, and the timing counts.
 * Assumes a 100 MHz system clock; included by bare name wherever a constant is used.
 */
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH

// instruction codes
`define FSR_CMD_ERS_SUSP 8'h75
`define FSR_CMD_ERS_RES 8'h7A
`define FSR_CMD_PRG_SUSP 8'h85
`define FSR_CMD_PRG_RES 8'h8A
`define FSR_CMD_ERASE 8'hD8
`define FSR_CMD_PROG 8'h02
`define FSR_CMD_READ 8'h03

// suspend parameter word fields, bit 31 down to bit 0
`define FSR_F_SUP 1'h0
`define FSR_F_ERS_LAT_UNIT 2'h2
`define FSR_F_ERS_LAT_CNT 5'h04
`define FSR_F_ERS_GAP_CNT 4'h1
`define FSR_F_PRG_LAT_UNIT 2'h2
`define FSR_F_PRG_LAT_CNT 5'h04
`define FSR_F_PRG_GAP_CNT 4'h1
`define FSR_F_RFU 1'h1
`define FSR_F_ERS_PROHIB 4'hE
`define FSR_F_PRG_PROHIB 4'hC

// where the word sits in the parameter space, and what the rest reads as
`define FSR_PRM_BASE 8'h2C
`define FSR_PRM_LAST 8'h2F
`define FSR_PRM_FILL 8'hFF
`define FSR_PRM_BYTE_W 8'h08

// address fields that bound the suspended sector and page
`define FSR_SECT_HI 23
`define FSR_SECT_LO 16
`define FSR_PAGE_HI 23
`define FSR_PAGE_LO 9

// timing
`define FSR_CLK_NS 10
`define FSR_SUSP_LAT_NS 40000
`define FSR_SUSP_LAT_CYC ((`FSR_SUSP_LAT_NS) / (`FSR_CLK_NS))
// last count before the forced stop: the counter starts one edge late and the
// state and status change one edge after the last count, so the status lands on the bound
`define FSR_SUSP_LAT_LAST ((`FSR_SUSP_LAT_CYC) - 2)
`define FSR_RES_GAP_NS 128000
`define FSR_RES_GAP_CYC (((`FSR_RES_GAP_NS) + (`FSR_CLK_NS) - 1) / (`FSR_CLK_NS))
`define FSR_LAT_W 12
`define FSR_GAP_W 14

`endif

/* File: fsr_pkg.sv */
/*
 * Types for the flash suspend/resume controller: device states and the packed
 * state records of both ends. Constants live in fsr_defines.svh.
 */
`include "fsr_defines.svh"

package fsr_pkg;

    typedef enum logic [3:0] {
        FSR_IDLE = 4'h1,
        FSR_BUSY = 4'h2,
        FSR_SUSPENDING = 4'h4,
        FSR_SUSPENDED = 4'h8
    } fsr_state_t;

    typedef struct packed {
        fsr_state_t state;
        logic is_erase;
        logic [`FSR_LAT_W-1:0] lat_cnt;
        logic pause;
        logic late;
        logic fwd_valid;
        logic [7:0] fwd_code;
        logic [23:0] fwd_addr;
        logic prm_valid;
        logic [7:0] prm_data;
        logic busy;
        logic ers_susp;
        logic prg_susp;
    } fsr_dev_t;

    typedef struct packed {
        logic cmd_valid;
        logic [7:0] cmd_code;
        logic [23:0] cmd_addr;
        logic prm_req;
        logic [7:0] prm_addr;
        logic usr_prm_valid;
        logic [7:0] usr_prm_data;
        logic ready;
        logic refused;
        logic pend;
        logic [7:0] pend_code;
        logic [`FSR_GAP_W-1:0] gap_cnt;
        logic [23:0] op_addr;
    } fsr_host_t;

endpackage : fsr_pkg

/* File: fsr_link_if.sv */
/*
 * Link between the host controller end and the flash end of the suspend/resume
 * controller. Both ends run on the same sys_clk_i; no crossing is needed.
 */
`timescale 1ns/1ps

interface fsr_link_if;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [23:0] cmd_addr;
    logic prm_req;
    logic [7:0] prm_addr;
    logic prm_valid;
    logic [7:0] prm_data;
    logic busy;
    logic ers_susp;
    logic prg_susp;

    modport host (
        output cmd_valid, cmd_code, cmd_addr, prm_req, prm_addr,
        input prm_valid, prm_data, busy, ers_susp, prg_susp
    );

    modport dev (
        input cmd_valid, cmd_code, cmd_addr, prm_req, prm_addr,
        output prm_valid, prm_data, busy, ers_susp, prg_susp
    );
endinterface : fsr_link_if

/* File: fsr_host.sv */
/*
 * Host controller end of the suspend/resume controller: sends user commands
 * over the link, holds a suspend back until the resume-to-suspend gap has passed,
 * refuses operations forbidden while an erase or program is suspended, and
 * relays parameter reads. Relies on the flash end's registered status.
 */
`timescale 1ns/1ps
`include "fsr_defines.svh"

module fsr_host #(
    parameter int unsigned RESUME_GAP_CYC = `FSR_RES_GAP_CYC
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    fsr_link_if.host link,
    input wire logic req_valid_i,
    input wire logic [7:0] req_code_i,
    input wire logic [23:0] req_addr_i,
    output logic req_ready_o,
    output logic refused_o,
    input wire logic prm_req_i,
    input wire logic [7:0] prm_addr_i,
    output logic prm_valid_o,
    output logic [7:0] prm_data_o
);

    fsr_pkg::fsr_host_t r_reg;
    fsr_pkg::fsr_host_t r_next;

    logic taken;
    logic is_susp;
    logic is_res;
    logic forbid;

    always_comb begin
        taken = req_valid_i && r_reg.ready;
        is_susp = req_code_i == `FSR_CMD_ERS_SUSP || req_code_i == `FSR_CMD_PRG_SUSP;
        is_res = req_code_i == `FSR_CMD_ERS_RES || req_code_i == `FSR_CMD_PRG_RES;
        forbid = 1'b0;
        if (req_code_i == `FSR_CMD_ERASE && (link.ers_susp || link.prg_susp)) begin
            forbid = 1'b1;
        end else if (req_code_i == `FSR_CMD_PROG && link.prg_susp) begin
            forbid = 1'b1;
        end else if (req_code_i == `FSR_CMD_READ && link.ers_susp
                && req_addr_i[`FSR_SECT_HI:`FSR_SECT_LO]
                == r_reg.op_addr[`FSR_SECT_HI:`FSR_SECT_LO]) begin
            forbid = 1'b1;
        end else if (req_code_i == `FSR_CMD_READ && link.prg_susp
                && req_addr_i[`FSR_PAGE_HI:`FSR_PAGE_LO]
                == r_reg.op_addr[`FSR_PAGE_HI:`FSR_PAGE_LO]) begin
            forbid = 1'b1;
        end
    end

    always_comb begin
        r_next = r_reg;
        r_next.cmd_valid = 1'b0;
        r_next.refused = 1'b0;
        r_next.prm_req = prm_req_i;
        r_next.prm_addr = prm_addr_i;
        r_next.usr_prm_valid = link.prm_valid;
        if (link.prm_valid) begin
            r_next.usr_prm_data = link.prm_data;
        end
        if (r_reg.gap_cnt != '0) begin
            r_next.gap_cnt = `FSR_GAP_W'(r_reg.gap_cnt - 1'b1);
        end

        if (r_reg.pend && r_reg.gap_cnt == '0) begin
            // held suspend goes out as soon as the gap has run out
            r_next.pend = 1'b0;
            r_next.ready = 1'b1;
            r_next.cmd_valid = 1'b1;
            r_next.cmd_code = r_reg.pend_code;
        end else if (taken && forbid) begin
            r_next.refused = 1'b1;
        end else if (taken && is_susp && r_reg.gap_cnt != '0) begin
            r_next.pend = 1'b1;
            r_next.pend_code = req_code_i;
            r_next.ready = 1'b0;
        end else if (taken) begin
            r_next.cmd_valid = 1'b1;
            r_next.cmd_code = req_code_i;
            r_next.cmd_addr = req_addr_i;
            if (is_res) begin
                r_next.gap_cnt = `FSR_GAP_W'(RESUME_GAP_CYC);
            end
            // a program sent during an erase suspend must not move the guarded sector
            if ((req_code_i == `FSR_CMD_ERASE || req_code_i == `FSR_CMD_PROG)
                    && !link.ers_susp && !link.prg_susp) begin
                r_next.op_addr = req_addr_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r_reg <= '0;
            r_reg.ready <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.cmd_valid = r_reg.cmd_valid;
    assign link.cmd_code = r_reg.cmd_code;
    assign link.cmd_addr = r_reg.cmd_addr;
    assign link.prm_req = r_reg.prm_req;
    assign link.prm_addr = r_reg.prm_addr;

    assign req_ready_o = r_reg.ready;
    assign refused_o = r_reg.refused;
    assign prm_valid_o = r_reg.usr_prm_valid;
    assign prm_data_o = r_reg.usr_prm_data;

endmodule : fsr_host

/* File: fsr_link_props.sv */
/*
 * Checker for the link between the host end and the flash end: parameter
 * answers, suspend deadline, resume status, resume-to-suspend gap, nesting.
 * Assumes one clock and the asynchronous active-low reset of both ends.
 */
`timescale 1ns/1ps
`include "fsr_defines.svh"

module fsr_link_props #(
    parameter int unsigned RESUME_GAP_CYC = `FSR_RES_GAP_CYC
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic prm_req,
    input wire logic [7:0] prm_addr,
    input wire logic prm_valid,
    input wire logic [7:0] prm_data,
    input wire logic busy,
    input wire logic ers_susp,
    input wire logic prg_susp
);
    logic [31:0] gap_cnt_reg;
    logic [12:0] susp_cnt_reg;

    function automatic logic [7:0] prm_byte(input logic [7:0] a);
        logic [31:0] w;
        w = 32'h441883EC;
        return (a >= 8'h2C && a <= 8'h2F) ? w[8*(a-8'h2C) +: 8] : 8'hFF;
    endfunction : prm_byte

    // counters kept here since both waits run far past what a delay range may span
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_cnt_reg <= 32'h0;
            susp_cnt_reg <= 13'h0;
        end else begin
            if (cmd_valid && (cmd_code == 8'h7A || cmd_code == 8'h8A)) begin
                gap_cnt_reg <= RESUME_GAP_CYC;
            end else if (gap_cnt_reg != 32'h0) begin
                gap_cnt_reg <= gap_cnt_reg - 32'h1;
            end
            if (!busy) begin
                susp_cnt_reg <= 13'h0;
            end else if (cmd_valid && (cmd_code == 8'h75 || cmd_code == 8'h85)) begin
                susp_cnt_reg <= 13'h1;
            end else if (susp_cnt_reg != 13'h0) begin
                susp_cnt_reg <= susp_cnt_reg + 13'h1;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    chk_prm_answer: assert property (prm_req |=> prm_valid && prm_data == prm_byte($past(prm_addr)))
        else $error("parameter answer wrong");
    chk_susp_deadline: assert property (susp_cnt_reg <= 13'hFA0)
        else $error("suspend took longer than 4000 cycles");
    chk_susp_pending: assert property (cmd_valid && cmd_code == 8'h75 && busy && !ers_susp |=> busy)
        else $error("busy dropped before erase suspended");
    chk_ers_resume: assert property (cmd_valid && cmd_code == 8'h7A && ers_susp |=> busy && !ers_susp)
        else $error("erase resume not taken");
    chk_prg_resume: assert property (cmd_valid && cmd_code == 8'h8A && prg_susp |=> busy && !prg_susp)
        else $error("program resume not taken");
    chk_resume_gap: assert property (cmd_valid && (cmd_code == 8'h75 || cmd_code == 8'h85) |-> gap_cnt_reg == 32'h0)
        else $error("suspend sent inside resume gap");
    chk_no_erase_nest: assert property (cmd_valid && cmd_code == 8'hD8 |-> !ers_susp && !prg_susp)
        else $error("erase sent while suspended");
    chk_no_prog_nest: assert property (cmd_valid && cmd_code == 8'h02 |-> !prg_susp)
        else $error("program sent while program suspended");
    chk_susp_idle: assert property (ers_susp || prg_susp |-> !busy && !(ers_susp && prg_susp))
        else $error("suspended status inconsistent");
endmodule : fsr_link_props

/* File: flash_suspend_resume_control_test.sv */
/*
 * Self-checking bench: both ends joined by fsr_link_if, array engine played here.
 * Assumes the design files and fsr_link_props.sv are compiled first.
 */
`timescale 1ns/1ps

module flash_suspend_resume_control_test;
    localparam int GAP = 20;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic op_start_i = 1'b0, op_is_erase_i = 1'b0, op_done_i = 1'b0, array_paused_i = 1'b0;
    logic req_valid_i = 1'b0, prm_req_i = 1'b0;
    logic [7:0] req_code_i = 8'h00, prm_addr_i = 8'h00;
    logic [23:0] req_addr_i = 24'h000000;
    logic array_pause_o, late_o, fwd_valid_o, busy_o, ers_susp_o, prg_susp_o;
    logic req_ready_o, refused_o, prm_valid_o;
    logic [7:0] fwd_code_o, prm_data_o;
    logic [23:0] fwd_addr_o;
    logic [23:0] oa = 24'h000000;
    int err_count = 0, check_count = 0, cyc = 0, es = 0, ps = 0;
    int stamp[256];

    fsr_link_if link ();
    fsr_dev u_fsr_dev (.sys_clk_i, .reset_n_i, .link(link), .op_start_i, .op_is_erase_i,
        .op_done_i, .array_paused_i, .array_pause_o, .late_o, .fwd_valid_o, .fwd_code_o,
        .fwd_addr_o, .busy_o, .ers_susp_o, .prg_susp_o);
    fsr_host #(.RESUME_GAP_CYC(GAP)) u_fsr_host (.sys_clk_i, .reset_n_i, .link(link),
        .req_valid_i, .req_code_i, .req_addr_i, .req_ready_o, .refused_o, .prm_req_i,
        .prm_addr_i, .prm_valid_o, .prm_data_o);
    fsr_link_props #(.RESUME_GAP_CYC(GAP)) u_fsr_link_props (.sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
        .prm_req(link.prm_req), .prm_addr(link.prm_addr), .prm_valid(link.prm_valid),
        .prm_data(link.prm_data), .busy(link.busy), .ers_susp(link.ers_susp),
        .prg_susp(link.prg_susp));

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        cyc++;
        if (link.cmd_valid === 1'b1) stamp[link.cmd_code] = cyc;
    end

    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic hang;
        check("wait", 1, 0);
        stop_test();
    endtask : hang

    // host-side refusal model: one remembered operation address, as the host keeps
    function automatic logic refuse(input logic [7:0] c, input logic [23:0] a);
        if (c == 8'hD8) return es || ps;
        if (c == 8'h02) return ps != 0;
        if (c == 8'h03) return (es && a[23:16] == oa[23:16]) || (ps && a[23:9] == oa[23:9]);
        return 1'b0;
    endfunction : refuse

    task automatic req(input logic [7:0] c, input logic [23:0] a);
        int n;
        int fw;
        int rf;
        logic r;
        logic fe;
        logic [7:0] fc;
        logic [23:0] fa;
        r = refuse(c, a);
        fe = !r && c != 8'h75 && c != 8'h7A && c != 8'h85 && c != 8'h8A;
        req_valid_i = 1'b1;
        req_code_i = c;
        req_addr_i = a;
        n = 0;
        while (req_ready_o !== 1'b1) begin
            tick();
            n++;
            if (n > 300) hang();
        end
        tick();
        req_valid_i = 1'b0;
        fw = 0;
        rf = 0;
        fc = 8'h00;
        fa = 24'h000000;
        repeat (4) begin
            if (fwd_valid_o === 1'b1) begin
                fc = fwd_code_o;
                fa = fwd_addr_o;
            end
            fw += (fwd_valid_o === 1'b1);
            rf += (refused_o === 1'b1);
            tick();
        end
        if (fe && c != 8'h03 && !es && !ps) oa = a;
        check("forward and refuse", {fe, r}, {fw[0], rf[0]});
        if (fe) check("forwarded code", c, fc);
        if (fe) check("forwarded addr", a, fa);
    endtask : req

    task automatic wait_stat(input string name, input logic [2:0] exp, input int lim);
        int n;
        n = 0;
        while ({busy_o, ers_susp_o, prg_susp_o} !== exp) begin
            tick();
            n++;
            if (n > lim) hang();
        end
        check(name, exp, {busy_o, ers_susp_o, prg_susp_o});
    endtask : wait_stat

    task automatic engine(input logic p, input logic d);
        array_paused_i = p;
        op_done_i = d;
        tick();
        array_paused_i = 1'b0;
        op_done_i = 1'b0;
    endtask : engine

    task automatic op(input logic e);
        op_start_i = 1'b1;
        op_is_erase_i = e;
        tick();
        op_start_i = 1'b0;
        tick();
    endtask : op

    // even steps aim inside the suspended sector or page, odd steps anywhere
    task automatic probe;
        int k;
        logic [23:0] a;
        for (int i = 0; i < 8; i++) begin
            k = (i < 3) ? 2 - i : $urandom_range(2);
            a = ps ? {oa[23:9], 9'($urandom)} : {oa[23:16], 16'($urandom)};
            if (i % 2) a = 24'($urandom);
            req(k == 0 ? 8'hD8 : (k == 1 ? 8'h02 : 8'h03), a);
        end
    endtask : probe

    initial begin
        logic [31:0] w;
        int k;
        void'($urandom(18938));
        w = (32'h2 << 29) | (32'h4 << 24) | (32'h1 << 20) | (32'h2 << 18) | (32'h4 << 13);
        w = w | (32'h1 << 9) | (32'h1 << 8) | (32'hE << 4) | 32'hC;
        tick(8);
        reset_n_i = 1'b1;
        check("ready after reset", 1, req_ready_o);
        for (int i = 0; i < 6; i++) begin
            k = (i < 4) ? 'h2C + i : 'h30 + $urandom_range(200);
            prm_addr_i = k[7:0];
            prm_req_i = 1'b1;
            tick();
            prm_req_i = 1'b0;
            tick(2);
            check("prm byte", {1'b1, (i < 4) ? w[8*i +: 8] : 8'hFF}, {prm_valid_o, prm_data_o});
        end
        $display("test parameter done");
        req(8'hD8, 24'($urandom));
        op(1'b1);
        wait_stat("erase busy", 3'b100, 5);
        req(8'h75, 24'h0);
        check("erase pausing", 4'b1001, {busy_o, ers_susp_o, prg_susp_o, array_pause_o});
        engine(1'b1, 1'b0);
        wait_stat("erase suspended", 3'b010, 10);
        check("late flag", 0, late_o);
        es = 1;
        probe();
        req(8'h7A, 24'h0);
        es = 0;
        check("erase resumed", 4'b1000, {busy_o, ers_susp_o, prg_susp_o, array_pause_o});
        req(8'h75, 24'h0);
        tick(GAP + 2);
        engine(1'b1, 1'b0);
        wait_stat("erase suspended again", 3'b010, 10);
        k = stamp[8'h75] - stamp[8'h7A];
        check("resume gap", 1, k > GAP && k < GAP + 3);
        req(8'h7A, 24'h0);
        engine(1'b0, 1'b1);
        wait_stat("erase finished", 3'b000, 5);
        $display("test erase done");
        req(8'h02, 24'($urandom));
        op(1'b0);
        req(8'h85, 24'h0);
        wait_stat("program suspended", 3'b001, 4100);
        check("suspend deadline", 1, cyc - stamp[8'h85] <= 4000);
        check("late flag", 1, late_o);
        ps = 1;
        probe();
        req(8'h8A, 24'h0);
        ps = 0;
        check("program resumed", 4'b1000,
            {busy_o, ers_susp_o, prg_susp_o, array_pause_o});
        engine(1'b0, 1'b1);
        wait_stat("program finished", 3'b000, 5);
        $display("test program done");
        stop_test();
    end
endmodule : flash_suspend_resume_control_test
